// *** ppmp_regs.vh ***
// Register offsets, field positions, reset values and mode codes for the parallel port block.
//
// Overview of operation
// - Byte-enable pin is active-high when its polarity bit is 1, else active-low.
// - In slave modes and master mode 2, write polarity bit sets the write strobe level.
// - In master mode 1, the write polarity bit sets the enable strobe level instead.
// - In slave modes and master mode 2, read polarity bit sets the read strobe level.
// - In master mode 1, the read polarity bit sets the direction strobe level instead.
// - Pin-related control bits do nothing while that pin carries an address line.
// - Busy reads 1 during a master transfer, 0 otherwise; meaningless while stalled.
// - Interrupt mode 11 interrupts on buffer 3 access, or address bits 11 when addressable.
// - Interrupt mode 10 raises no interrupt and stalls the processor until the cycle ends.
// - Interrupt mode 01 interrupts at each transfer end, after both byte cycles in 16-bit width; mode 00 never interrupts.
// - Step mode 11 advances legacy slave read and write buffer pointers after each access.
// - Step mode 10 decrements the 11-bit address counter after every cycle.
// - Step mode 01 increments the 11-bit address counter after every cycle.
// - Step mode 00 leaves the address counter unchanged.
// - In 16-bit width one data register access starts two byte transfers.
// - Mode 11 is master mode 1: chip select, direction, enable, byte enable, address, data.
`ifndef PPMP_REGS_VH
`define PPMP_REGS_VH

// Register indices on the plain register port.
`define PPMP_IDX_CTRL      3'h0
`define PPMP_IDX_MODE      3'h1
`define PPMP_IDX_ADDR      3'h2
`define PPMP_IDX_DATA      3'h3
`define PPMP_IDX_BUF_BASE  3'h4

// Control register fields.
`define PPMP_CTL_EN        15
`define PPMP_CTL_BEADDR    11
`define PPMP_CTL_BEEN      10
`define PPMP_CTL_WREN      9
`define PPMP_CTL_RDEN      8
`define PPMP_CTL_CSP       3
`define PPMP_CTL_BEP       2
`define PPMP_CTL_WRP       1
`define PPMP_CTL_RDP       0
`define PPMP_CTL_MASK      16'h8f0f

// Mode register fields.
`define PPMP_MOD_BUSY      15
`define PPMP_MOD_IRQ_HI    14
`define PPMP_MOD_IRQ_LO    13
`define PPMP_MOD_STEP_HI   12
`define PPMP_MOD_STEP_LO   11
`define PPMP_MOD_WIDE      10
`define PPMP_MOD_PM_HI     9
`define PPMP_MOD_PM_LO     8
`define PPMP_MOD_WB_HI     7
`define PPMP_MOD_WB_LO     6
`define PPMP_MOD_WM_HI     5
`define PPMP_MOD_WM_LO     2
`define PPMP_MOD_WE_HI     1
`define PPMP_MOD_WE_LO     0

// Reset values.
`define PPMP_CTRL_RST      16'h0000
`define PPMP_MODE_RST      15'h0000
`define PPMP_ADDR_RST      11'h000

// Port mode, interrupt mode and step mode codes.
`define PPMP_PM_LEGACY     2'h0
`define PPMP_PM_ADDRSLV    2'h1
`define PPMP_PM_MASTER2    2'h2
`define PPMP_PM_MASTER1    2'h3
`define PPMP_IRQ_NONE      2'h0
`define PPMP_IRQ_CYCLE     2'h1
`define PPMP_IRQ_STALL     2'h2
`define PPMP_IRQ_BUF3      2'h3
`define PPMP_STEP_NONE     2'h0
`define PPMP_STEP_INC      2'h1
`define PPMP_STEP_DEC      2'h2
`define PPMP_STEP_BUF      2'h3

`endif

// *** ppmp_port.v ***
// Parallel master/slave port with polarity, mode, busy, interrupt, stall and address stepping.
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ps
`include "ppmp_regs.vh"

module ppmp_port (
  // Clock and reset.
  input  wire        clk_i,
  input  wire        rst_i,
  // Register port.
  input  wire [2:0]  reg_addr_i,
  input  wire [15:0] reg_wdata_i,
  input  wire        reg_we_i,
  input  wire        reg_re_i,
  output wire [15:0] reg_rdata_o,
  // Processor side events.
  output wire        irq_o,
  output wire        stall_o,
  // Address and byte enable pins.
  output wire [10:0] port_address_lines_o,
  output wire        byte_enable_pin_o,
  output wire        byte_enable_pin_oe_o,
  // Chip select pin.
  input  wire        chip_select_pin_i,
  output wire        chip_select_pin_o,
  output wire        chip_select_pin_oe_o,
  // Write strobe pin, enable strobe in master mode 1.
  input  wire        write_strobe_pin_i,
  output wire        write_strobe_pin_o,
  output wire        write_strobe_pin_oe_o,
  // Read strobe pin, direction strobe in master mode 1.
  input  wire        read_strobe_pin_i,
  output wire        read_strobe_pin_o,
  output wire        read_strobe_pin_oe_o,
  // Data pins and slave address inputs.
  input  wire [7:0]  port_data_i,
  output wire [7:0]  port_data_o,
  output wire [7:0]  port_data_oe_o,
  input  wire [1:0]  slave_addr_i
);

  localparam ST_IDLE  = 2'h0;
  localparam ST_SETUP = 2'h1;
  localparam ST_STRB  = 2'h2;
  localparam ST_HOLD  = 2'h3;

  // Returns a byte lane of a 16-bit word.
  function [7:0] lane;
    input [15:0] w;
    input        hi;
    begin
      lane = hi ? w[15:8] : w[7:0];
    end
  endfunction

  reg  [15:0] ctrl_q;
  reg  [14:0] mode_q;
  reg  [10:0] addr_q;
  reg  [15:0] data_q;
  reg  [7:0]  out_buf [0:3];
  reg  [7:0]  in_buf  [0:3];
  reg  [1:0]  rptr_q;
  reg  [1:0]  wptr_q;
  reg  [1:0]  st_q;
  reg  [1:0]  st_d;
  reg  [3:0]  cnt_q;
  reg  [3:0]  cnt_d;
  reg         dir_rd_q;
  reg         hi_q;
  reg  [15:0] rdata_q;
  reg         irq_q;
  reg         stall_q;
  reg         be_q;
  reg         be_oe_q;
  reg         cs_q;
  reg         cs_oe_q;
  reg         wr_q;
  reg         wr_oe_q;
  reg         rd_q;
  reg         rd_oe_q;
  reg  [7:0]  dout_q;
  reg  [7:0]  doe_q;
  // Synchroniser stages for the pins.
  reg  [1:0]  cs_sy_q;
  reg  [1:0]  wr_sy_q;
  reg  [1:0]  rd_sy_q;
  reg  [7:0]  din_s1_q;
  reg  [7:0]  din_s2_q;
  reg  [1:0]  sa_s1_q;
  reg  [1:0]  sa_s2_q;
  reg         s_wr_prev_q;
  reg         s_rd_prev_q;

  wire [1:0]  pmode   = mode_q[`PPMP_MOD_PM_HI:`PPMP_MOD_PM_LO];
  wire [1:0]  irqm    = mode_q[`PPMP_MOD_IRQ_HI:`PPMP_MOD_IRQ_LO];
  wire [1:0]  stepm   = mode_q[`PPMP_MOD_STEP_HI:`PPMP_MOD_STEP_LO];
  wire        wide    = mode_q[`PPMP_MOD_WIDE];
  wire        en      = ctrl_q[`PPMP_CTL_EN];
  wire        master  = pmode[1];
  wire        busy    = (st_q != ST_IDLE);
  wire        sw_data = en && master && !busy && (reg_addr_i == `PPMP_IDX_DATA);
  wire        start_w = sw_data && reg_we_i;
  wire        start_r = sw_data && reg_re_i;
  wire        cyc_end = (st_q == ST_HOLD) && (cnt_q == 4'h0);
  wire        more    = wide && !hi_q;
  wire        dir_rd  = (st_q == ST_IDLE) ? start_r : dir_rd_q;

  // Slave side strobes, qualified by chip select, taken at the polarity selected.
  wire        s_cs    = (cs_sy_q[1] == ctrl_q[`PPMP_CTL_CSP]);
  wire        s_wr    = en && !master && s_cs && (wr_sy_q[1] == ctrl_q[`PPMP_CTL_WRP]);
  wire        s_rd    = en && !master && s_cs && (rd_sy_q[1] == ctrl_q[`PPMP_CTL_RDP]);
  wire        s_wend  = s_wr_prev_q && !s_wr;
  wire        s_rend  = s_rd_prev_q && !s_rd;
  wire        addrslv = (pmode == `PPMP_PM_ADDRSLV);
  wire [1:0]  s_wsel  = addrslv ? sa_s2_q : wptr_q;
  wire [1:0]  s_rsel  = addrslv ? sa_s2_q : rptr_q;
  wire        s_end   = s_wend || s_rend;
  wire        s_buf3  = (s_wend && (s_wsel == 2'h3)) || (s_rend && (s_rsel == 2'h3));

  // Master cycle sequencer: setup, strobe and hold phases with programmed waits.
  always @* begin
    st_d  = st_q;
    cnt_d = cnt_q;
    case (st_q)
      ST_IDLE: begin
        if (start_w || start_r) begin
          st_d  = ST_SETUP;
          cnt_d = {2'h0, mode_q[`PPMP_MOD_WB_HI:`PPMP_MOD_WB_LO]};
        end
      end
      ST_SETUP: begin
        if (cnt_q == 4'h0) begin
          st_d  = ST_STRB;
          cnt_d = mode_q[`PPMP_MOD_WM_HI:`PPMP_MOD_WM_LO];
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      ST_STRB: begin
        if (cnt_q == 4'h0) begin
          st_d  = ST_HOLD;
          cnt_d = {2'h0, mode_q[`PPMP_MOD_WE_HI:`PPMP_MOD_WE_LO]};
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      ST_HOLD: begin
        if (cnt_q != 4'h0) begin
          cnt_d = cnt_q - 4'h1;
        end else if (more) begin
          st_d  = ST_SETUP;
          cnt_d = {2'h0, mode_q[`PPMP_MOD_WB_HI:`PPMP_MOD_WB_LO]};
        end else begin
          st_d  = ST_IDLE;
        end
      end
      default: begin
        st_d  = ST_IDLE;
        cnt_d = 4'h0;
      end
    endcase
  end

  // Active-high internal strobes, taken from the next state so the pins change with it.
  wire        m_strb = (st_d == ST_STRB);
  wire        m_act  = (st_d != ST_IDLE);
  wire        wr_act = (pmode == `PPMP_PM_MASTER1) ? m_strb : (m_strb && !dir_rd);
  wire        rd_act = (pmode == `PPMP_PM_MASTER1) ? (m_act && dir_rd) : (m_strb && dir_rd);
  wire        cs_act = m_act;
  wire        be_act = m_act && wide;

  // Pin synchronisers; only the second stage is read by logic.
  always @(posedge clk_i) begin
    if (rst_i) begin
      cs_sy_q  <= 2'h0;
      wr_sy_q  <= 2'h0;
      rd_sy_q  <= 2'h0;
      din_s1_q <= 8'h00;
      din_s2_q <= 8'h00;
      sa_s1_q  <= 2'h0;
      sa_s2_q  <= 2'h0;
    end else begin
      cs_sy_q  <= {cs_sy_q[0], chip_select_pin_i};
      wr_sy_q  <= {wr_sy_q[0], write_strobe_pin_i};
      rd_sy_q  <= {rd_sy_q[0], read_strobe_pin_i};
      din_s1_q <= port_data_i;
      din_s2_q <= din_s1_q;
      sa_s1_q  <= slave_addr_i;
      sa_s2_q  <= sa_s1_q;
    end
  end

  // Register file, master data path, address stepping and slave pointers.
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q      <= `PPMP_CTRL_RST;
      mode_q      <= `PPMP_MODE_RST;
      addr_q      <= `PPMP_ADDR_RST;
      data_q      <= 16'h0000;
      st_q        <= ST_IDLE;
      cnt_q       <= 4'h0;
      dir_rd_q    <= 1'b0;
      hi_q        <= 1'b0;
      rptr_q      <= 2'h0;
      wptr_q      <= 2'h0;
      rdata_q     <= 16'h0000;
      s_wr_prev_q <= 1'b0;
      s_rd_prev_q <= 1'b0;
    end else begin
      st_q        <= st_d;
      cnt_q       <= cnt_d;
      s_wr_prev_q <= s_wr;
      s_rd_prev_q <= s_rd;
      if (st_q == ST_IDLE) begin
        dir_rd_q <= start_r;
        hi_q     <= 1'b0;
      end
      // Software writes; the data register is refused while a transfer runs.
      if (reg_we_i) begin
        case (reg_addr_i)
          `PPMP_IDX_CTRL: ctrl_q <= reg_wdata_i & `PPMP_CTL_MASK;
          `PPMP_IDX_MODE: mode_q <= reg_wdata_i[14:0];
          `PPMP_IDX_ADDR: addr_q <= reg_wdata_i[10:0];
          `PPMP_IDX_DATA: if (!busy) data_q <= wide ? reg_wdata_i : {8'h00, reg_wdata_i[7:0]};
          default:        out_buf[reg_addr_i[1:0]] <= reg_wdata_i[7:0];
        endcase
      end
      // Read data stand in the cycle after the strobe.
      if (reg_re_i) begin
        case (reg_addr_i)
          `PPMP_IDX_CTRL: rdata_q <= ctrl_q;
          `PPMP_IDX_MODE: rdata_q <= {busy, mode_q};
          `PPMP_IDX_ADDR: rdata_q <= {5'h00, addr_q};
          `PPMP_IDX_DATA: rdata_q <= data_q;
          default:        rdata_q <= {8'h00, in_buf[reg_addr_i[1:0]]};
        endcase
      end
      // Byte capture and address stepping at the end of each master byte cycle.
      if (cyc_end) begin
        if (dir_rd_q) begin
          if (hi_q) begin
            data_q[15:8] <= din_s2_q;
          end else begin
            data_q[7:0]  <= din_s2_q;
          end
        end
        hi_q <= more;
        case (stepm)
          `PPMP_STEP_INC: addr_q <= addr_q + 11'h001;
          `PPMP_STEP_DEC: addr_q <= addr_q - 11'h001;
          default:        addr_q <= addr_q;
        endcase
      end
      // Slave accesses complete when the strobe goes inactive.
      if (s_wend) begin
        in_buf[s_wsel] <= din_s2_q;
        if (stepm == `PPMP_STEP_BUF && pmode == `PPMP_PM_LEGACY) begin
          wptr_q <= wptr_q + 2'h1;
        end
      end
      if (s_rend && stepm == `PPMP_STEP_BUF && pmode == `PPMP_PM_LEGACY) begin
        rptr_q <= rptr_q + 2'h1;
      end
    end
  end

  // Interrupt pulse and processor stall.
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_q   <= 1'b0;
      stall_q <= 1'b0;
    end else begin
      case (irqm)
        `PPMP_IRQ_CYCLE: irq_q <= (cyc_end && !more) || s_end;
        `PPMP_IRQ_BUF3:  irq_q <= s_buf3;
        default:         irq_q <= 1'b0;
      endcase
      stall_q <= (irqm == `PPMP_IRQ_STALL) && (st_d != ST_IDLE);
    end
  end

  // Pin drivers: the polarity is folded into the same flop as the strobe.
  always @(posedge clk_i) begin
    if (rst_i) begin
      be_q    <= 1'b1;
      be_oe_q <= 1'b0;
      cs_q    <= 1'b1;
      cs_oe_q <= 1'b0;
      wr_q    <= 1'b1;
      wr_oe_q <= 1'b0;
      rd_q    <= 1'b1;
      rd_oe_q <= 1'b0;
      dout_q  <= 8'h00;
      doe_q   <= 8'h00;
    end else begin
      if (ctrl_q[`PPMP_CTL_BEADDR]) begin
        be_q <= addr_q[0];
      end else begin
        be_q <= be_act ^ ~ctrl_q[`PPMP_CTL_BEP];
      end
      be_oe_q <= en && master && (ctrl_q[`PPMP_CTL_BEEN] || ctrl_q[`PPMP_CTL_BEADDR]);
      cs_q    <= cs_act ^ ~ctrl_q[`PPMP_CTL_CSP];
      cs_oe_q <= en && master;
      wr_q    <= wr_act ^ ~ctrl_q[`PPMP_CTL_WRP];
      wr_oe_q <= en && master && ctrl_q[`PPMP_CTL_WREN];
      rd_q    <= rd_act ^ ~ctrl_q[`PPMP_CTL_RDP];
      rd_oe_q <= en && master && ctrl_q[`PPMP_CTL_RDEN];
      if (master) begin
        dout_q <= lane(data_q, (st_q == ST_HOLD && cnt_q == 4'h0) ? more : hi_q);
        doe_q  <= {8{en && m_act && !dir_rd}};
      end else begin
        dout_q <= out_buf[s_rsel];
        doe_q  <= {8{s_rd}};
      end
    end
  end

  assign reg_rdata_o           = rdata_q;
  assign irq_o                 = irq_q;
  assign stall_o               = stall_q;
  assign port_address_lines_o  = addr_q;
  assign byte_enable_pin_o     = be_q;
  assign byte_enable_pin_oe_o  = be_oe_q;
  assign chip_select_pin_o     = cs_q;
  assign chip_select_pin_oe_o  = cs_oe_q;
  assign write_strobe_pin_o    = wr_q;
  assign write_strobe_pin_oe_o = wr_oe_q;
  assign read_strobe_pin_o     = rd_q;
  assign read_strobe_pin_oe_o  = rd_oe_q;
  assign port_data_o           = dout_q;
  assign port_data_oe_o        = doe_q;

endmodule // ppmp_port

// *** ppmp_checker.sv ***
// Checker of port timing, polarity and address stepping relations.
`timescale 1ns/1ps
module ppmp_checker (
  // Clock and reset.
  input wire        clk_i,
  input wire        rst_i,
  // Register port.
  input wire [2:0]  reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire        reg_we_i,
  input wire [15:0] reg_rdata_o,
  // Events and pins.
  input wire        irq_o,
  input wire        stall_o,
  input wire [10:0] port_address_lines_o,
  input wire        write_strobe_pin_o,
  input wire        read_strobe_pin_o
);
  reg [15:0] ctl_q;
  reg [15:0] mod_q;
  reg [1:0]  quiet_q;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Shadows setup writes and counts calm cycles, since pins follow a write one cycle late.
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctl_q <= 16'h0000;
      mod_q <= 16'h0000;
      quiet_q <= 2'h0;
    end else if (reg_we_i && reg_addr_i < 3'h3) begin
      quiet_q <= 2'h0;
      if (reg_addr_i == 3'h0) ctl_q <= reg_wdata_i & 16'h8f0f;
      if (reg_addr_i == 3'h1) mod_q <= reg_wdata_i;
    end else if (quiet_q != 2'h2) begin
      quiet_q <= quiet_q + 2'h1;
    end
  end
  chk_reset_clears: assert property (disable iff (1'b0) rst_i |=> reg_rdata_o == 16'h0000 && !irq_o && !stall_o)
    else $error("outputs not cleared by reset");
  chk_irq_pulse: assert property (irq_o |=> !irq_o)
    else $error("interrupt longer than one cycle");
  chk_irq_none: assert property (quiet_q == 2'h2 && mod_q[14:13] == 2'h0 |-> !irq_o)
    else $error("interrupt in silent mode");
  chk_stall_only: assert property (stall_o |-> mod_q[14:13] == 2'h2 && !irq_o)
    else $error("stall outside stall mode or with interrupt");
  chk_stall_len: assert property ($rose(stall_o) && !mod_q[10] && mod_q[7:0] == 8'h00
    |-> stall_o [*3] ##1 !stall_o)
    else $error("stall length wrong");
  chk_wr_strobe: assert property (quiet_q == 2'h2 && ctl_q[15] && ctl_q[9] && mod_q[9] && mod_q[5:2] == 4'h0
    && write_strobe_pin_o == ctl_q[1] |=> write_strobe_pin_o != ctl_q[1])
    else $error("write or enable strobe wrong");
  chk_rd_strobe: assert property (quiet_q == 2'h2 && ctl_q[15] && ctl_q[8] && mod_q[9:8] == 2'h2
    && mod_q[5:2] == 4'h0 && read_strobe_pin_o == ctl_q[0] |=> read_strobe_pin_o != ctl_q[0])
    else $error("read strobe wrong");
  chk_addr_inc: assert property (quiet_q == 2'h2 && mod_q[12:11] == 2'h1
    && !$stable(port_address_lines_o) |-> port_address_lines_o == $past(port_address_lines_o) + 11'h001)
    else $error("address not incremented by one");
  chk_addr_dec: assert property (quiet_q == 2'h2 && mod_q[12:11] == 2'h2
    && !$stable(port_address_lines_o) |-> port_address_lines_o == $past(port_address_lines_o) - 11'h001)
    else $error("address not decremented by one");
  chk_addr_hold: assert property (quiet_q == 2'h2 && mod_q[12:11] == 2'h0 |-> $stable(port_address_lines_o))
    else $error("address moved without stepping");
endmodule // ppmp_checker

// *** ppmp_peer.sv ***
// Model of the external peripheral that answers the port's master cycles.
`timescale 1ns/1ps
module ppmp_peer (
  // Clock.
  input  wire        clk_i,
  // Pins from the port.
  input  wire        cs_pin_i,
  input  wire        data_oe_i,
  input  wire [10:0] addr_i,
  // Slave-side requests from the bench.
  input  wire        slv_en_i,
  input  wire        slv_wr_i,
  input  wire [7:0]  slv_data_i,
  // Pins to the port.
  output wire [7:0]  data_o,
  output wire        cs_o,
  output wire        wr_o,
  output wire        rd_o,
  output wire [1:0]  slave_addr_o
);
  reg  [7:0] last_q;
  wire       drive;
  // Answers while selected (low) and the port is not driving; as a host it holds its byte; else shows the inverse.
  assign drive = (cs_pin_i == 1'b0) && !data_oe_i;
  assign data_o = drive ? (8'h80 ^ addr_i[7:0]) : (slv_en_i ? slv_data_i : ~last_q);
  // Host side of slave mode: select and write strobe are active low, reads stay idle.
  assign cs_o = ~slv_en_i;
  assign wr_o = ~slv_wr_i;
  assign rd_o = 1'b1;
  assign slave_addr_o = 2'h0;
  // Remembers the last byte handed over.
  always @(posedge clk_i) begin
    if (drive) last_q <= 8'h80 ^ addr_i[7:0];
  end
  initial last_q = 8'h00;
endmodule // ppmp_peer

// *** tb_ppmp_port.sv ***
// Self-checking bench for the parallel port block.
`timescale 1ns/1ps
module tb_ppmp_port;
  reg         clk_i, rst_i, reg_we_i, reg_re_i;
  reg  [2:0]  reg_addr_i;
  reg  [15:0] reg_wdata_i, v, dv, md;
  wire [15:0] reg_rdata_o;
  wire [10:0] adr;
  wire [7:0]  pd_i, pd_o, pd_oe;
  wire [1:0]  sa_i;
  wire        irq_o, stall_o, be_o, be_oe, cs_i, cs_o, cs_oe, wr_i, wr_o, wr_oe, rd_i, rd_o, rd_oe;
  integer     errors, check_count, irqs, stalls, cyc, i, n0, s0;
  reg  [2:0]  pol, seen;
  reg  [10:0] ea;
  reg         slv_en, slv_wr;
  reg  [7:0]  slv_data;
  ppmp_port ppmp_port_inst (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o), .stall_o(stall_o),
    .port_address_lines_o(adr), .byte_enable_pin_o(be_o), .byte_enable_pin_oe_o(be_oe),
    .chip_select_pin_i(cs_i), .chip_select_pin_o(cs_o), .chip_select_pin_oe_o(cs_oe),
    .write_strobe_pin_i(wr_i), .write_strobe_pin_o(wr_o), .write_strobe_pin_oe_o(wr_oe),
    .read_strobe_pin_i(rd_i), .read_strobe_pin_o(rd_o), .read_strobe_pin_oe_o(rd_oe),
    .port_data_i(pd_i), .port_data_o(pd_o), .port_data_oe_o(pd_oe), .slave_addr_i(sa_i));
  ppmp_peer ppmp_peer_inst (.clk_i(clk_i), .cs_pin_i(cs_o), .data_oe_i(pd_oe[0]), .addr_i(adr), .data_o(pd_i),
    .slv_en_i(slv_en), .slv_wr_i(slv_wr), .slv_data_i(slv_data),
    .cs_o(cs_i), .wr_o(wr_i), .rd_o(rd_i), .slave_addr_o(sa_i));
  // Clock of 50 ns period.
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // Notes strobe activity, interrupt and stall cycles, and cuts a hang short.
  always @(posedge clk_i) begin
    cyc = cyc + 1;
    if (irq_o === 1'b1) irqs = irqs + 1;
    if (stall_o === 1'b1) stalls = stalls + 1;
    if (be_o === pol[2]) seen[2] = 1'b1;
    if (wr_o === pol[1]) seen[1] = 1'b1;
    if (rd_o === pol[0]) seen[0] = 1'b1;
    if (cyc == 20000) begin
      errors = errors + 1;
      close_out;
    end
  end
  task chk(input [15:0] got, input [15:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("MISMATCH %0t seen %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [2:0] a, input [15:0] d);
    begin
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_we_i <= 1'b1;
      @(posedge clk_i);
      reg_we_i <= 1'b0;
    end
  endtask
  task rd(input [2:0] a, output [15:0] d);
    begin
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_re_i <= 1'b1;
      @(posedge clk_i);
      reg_re_i <= 1'b0;
      #1 d = reg_rdata_o;
    end
  endtask
  // Polls the busy flag until it clears.
  task idle;
    integer n;
    begin
      rd(3'h1, v);
      for (n = 0; n < 20 && v[15] !== 1'b0; n = n + 1) rd(3'h1, v);
      chk({15'h0000, v[15]}, 16'h0000);
    end
  endtask
  // Mode first, so a polarity change never meets a slave mode.
  task cfg(input [15:0] m, input [15:0] c);
    begin
      wr(3'h1, m);
      wr(3'h0, c);
      pol = c[2:0];
    end
  endtask
  task xfer(input isrd, input [15:0] d);
    begin
      @(posedge clk_i);
      #1 seen = 3'h0;
      if (isrd) rd(3'h3, dv);
      else wr(3'h3, d);
      idle;
    end
  endtask
  task close_out;
    begin
      $display("Checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
        $display("Testbench passed");
      end else begin
        $display("Testbench failed");
      end
      $finish;
    end
  endtask
  // Main sequence.
  initial begin
    errors = 0;
    check_count = 0;
    irqs = 0;
    stalls = 0;
    cyc = 0;
    pol = 3'h0;
    seen = 3'h0;
    slv_en = 1'b0;
    slv_wr = 1'b0;
    slv_data = 8'h00;
    rst_i = 1'b1;
    reg_we_i = 1'b0;
    reg_re_i = 1'b0;
    reg_addr_i = 3'h0;
    reg_wdata_i = 16'h0000;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(3'h0, v);
    chk(v, 16'h0000);
    rd(3'h1, v);
    chk(v, 16'h0000);
    chk({10'h000, be_oe, wr_oe, rd_oe, be_o, wr_o, rd_o}, 16'h0007);
    wr(3'h0, 16'hfff0);
    rd(3'h0, v);
    chk(v, 16'h8f00);
    // Every byte-enable, write and read polarity in master modes 2 and 1, with cycle interrupts and incrementing address.
    wr(3'h2, 16'h0010);
    ea = 11'h010;
    for (i = 0; i < 16; i = i + 1) begin
      cfg({3'h1, 2'h1, 1'b0, (i > 7) ? 2'h3 : 2'h2, 8'h00}, 16'h8700 | i[2:0]);
      n0 = irqs;
      xfer(1'b0, 16'h00c3);
      chk({13'h0000, seen}, 16'h0002);
      chk({13'h0000, be_o, wr_o, rd_o}, {13'h0000, ~pol});
      chk(irqs - n0, 16'h0001);
      ea = ea + 11'h001;
      chk({5'h00, adr}, {5'h00, ea});
      xfer(1'b1, 16'h0000);
      chk({13'h0000, seen}, (i > 7) ? 16'h0003 : 16'h0001);
      xfer(1'b1, 16'h0000);
      chk({8'h00, dv[7:0]}, {8'h00, 8'h80 ^ ea[7:0]});
      ea = ea + 11'h002;
    end
    cfg({3'h0, 2'h2, 1'b0, 2'h2, 8'h00}, 16'h8700);
    n0 = irqs;
    xfer(1'b0, 16'h005a);
    ea = ea - 11'h001;
    chk({5'h00, adr}, {5'h00, ea});
    chk(irqs - n0, 16'h0000);
    cfg({3'h2, 2'h0, 1'b0, 2'h2, 8'h00}, 16'h8700);
    s0 = stalls;
    xfer(1'b0, 16'h00a5);
    chk({5'h00, adr}, {5'h00, ea});
    chk(irqs - n0, 16'h0000);
    chk(stalls - s0, 16'h0003);
    // Wide data: one access gives two byte cycles, one interrupt.
    cfg({3'h1, 2'h1, 1'b1, 2'h2, 8'h00}, 16'h8700);
    n0 = irqs;
    seen = 3'h0;
    wr(3'h3, 16'h1234);
    rd(3'h1, v);
    chk({15'h0000, v[15]}, 16'h0001);
    idle;
    chk({15'h0000, seen[2]}, 16'h0001);
    ea = ea + 11'h002;
    chk({5'h00, adr}, {5'h00, ea});
    chk(irqs - n0, 16'h0001);
    xfer(1'b1, 16'h0000);
    xfer(1'b1, 16'h0000);
    chk(dv, {8'h80 ^ (ea[7:0] + 8'h01), 8'h80 ^ ea[7:0]});
    // Byte enable pin carrying an address line ignores its polarity.
    cfg({3'h0, 2'h0, 1'b0, 2'h2, 8'h00}, 16'h8f00);
    wr(3'h2, 16'h0002);
    @(posedge clk_i);
    #1 chk({15'h0000, be_o}, 16'h0000);
    // Legacy slave writes step the write pointer, and the write to buffer 3 interrupts.
    cfg(16'h7800, 16'h8000);
    n0 = irqs;
    slv_en <= 1'b1;
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge clk_i);
      slv_wr <= 1'b1;
      slv_data <= 8'h30 + i[7:0];
      repeat (4) @(posedge clk_i);
      slv_wr <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
    slv_en <= 1'b0;
    for (i = 0; i < 4; i = i + 1) begin
      rd(3'h4 + i[2:0], v);
      chk(v, 16'h0030 + i[15:0]);
    end
    chk(irqs - n0, 16'h0001);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(3'h1, v);
    chk(v, 16'h0000);
    close_out;
  end
endmodule // tb_ppmp_port
bind ppmp_port ppmp_checker ppmp_checker_inst (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o), .stall_o(stall_o),
  .port_address_lines_o(port_address_lines_o), .write_strobe_pin_o(write_strobe_pin_o),
  .read_strobe_pin_o(read_strobe_pin_o));
